// >>> hw/updown_counter_defs.vh
// Purpose: Constants for the dual-clock up/down binary counter
// Assumes: Included by the counter design files by bare name
// Notes:   Definitions only; no logic lives here
`ifndef UPDOWN_COUNTER_DEFS_VH
`define UPDOWN_COUNTER_DEFS_VH

// ==========================================================
// Count geometry
`define CNT_WIDTH      4
`define CNT_MAX        4'hF
`define CNT_ZERO       4'h0

// ==========================================================
// Reset values
`define CNT_RESET      4'h0
`define CLK_IDLE_LEVEL 1'b1
`define TC_IDLE_LEVEL  1'b1

`endif

// >>> hw/count_clock_edge.v
// Purpose: Rising-edge finder for one count clock input
// Assumes: Input already synchronous to mclk
// Notes:   Tracks the level even while clear or preset blocks counting; holds it while clk_en is low
`timescale 1ns/10ps
`include "updown_counter_defs.vh"

module count_clock_edge (
	// Clock and control
	input  wire mclk,
	input  wire nrst,
	input  wire clk_en,
	// Count clock level
	input  wire level_in,
	// Results
	output wire rise
);

	reg level_q;

	// Idle high, so a clock held low through reset counts on its rise
	always @(posedge mclk) begin
		if (!nrst) begin
			level_q <= `CLK_IDLE_LEVEL;
		end else if (clk_en) begin
			level_q <= level_in;
		end
	end

	assign rise = clk_en & level_in & ~level_q;

endmodule // count_clock_edge

// >>> hw/count_bit_cell.v
// Purpose: One stage of the counter: a toggle flip-flop with
//          clear and preset steering
// Assumes: Toggle request already formed from the shared lines
// Notes:   Clear outranks preset, preset outranks toggling
`timescale 1ns/10ps
`include "updown_counter_defs.vh"

module count_bit_cell (
	// Clock and control
	input  wire mclk,
	input  wire nrst,
	input  wire clk_en,
	// Steering
	input  wire clear,
	input  wire load,
	input  wire load_bit,
	input  wire toggle,
	// State
	output reg  bit_d,
	output reg  bit_q
);

	always @* begin
		if (clear) begin
			bit_d = 1'b0;
		end else if (load) begin
			bit_d = load_bit;
		end else if (toggle) begin
			bit_d = ~bit_q;
		end else begin
			bit_d = bit_q;
		end
	end

	always @(posedge mclk) begin
		if (!nrst) begin
			bit_q <= 1'b0;
		end else if (clk_en) begin
			bit_q <= bit_d;
		end
	end

endmodule // count_bit_cell

// >>> hw/updown_binary_counter.v
// Purpose: Four-bit reversible binary counter with separate up and
//          down count clocks, preset, clear and terminal counts
// Assumes: All inputs synchronous to mclk (20 MHz); count clocks
//          are sampled levels, their rises found on mclk
// Notes:   Clear and preset act on the next mclk edge rather than
//          truly asynchronously; all outputs come from flip-flops
`timescale 1ns/10ps
`include "updown_counter_defs.vh"

module updown_binary_counter #(
	parameter WIDTH = `CNT_WIDTH
) (
	// Clock, reset, enable
	input  wire             mclk,
	input  wire             nrst,
	input  wire             clk_en,
	// Count clocks
	input  wire             count_up_clock,
	input  wire             count_down_clock,
	// Clear and preset
	input  wire             master_clear,
	input  wire             preset_load_n,
	input  wire [WIDTH-1:0] preset_data,
	// Count and terminal counts
	output wire [WIDTH-1:0] count_value,
	output reg              carry_out_n,
	output reg              borrow_out_n
);

	// ==========================================================
	// Count clock rises
	wire up_rise;
	wire down_rise;

	// Edge finders run during clear and load, so a clock held low
	// across them is counted on its next rise
	count_clock_edge u_up_edge (
		.mclk     (mclk),
		.nrst     (nrst),
		.clk_en   (clk_en),
		.level_in (count_up_clock),
		.rise     (up_rise)
	);

	count_clock_edge u_down_edge (
		.mclk     (mclk),
		.nrst     (nrst),
		.clk_en   (clk_en),
		.level_in (count_down_clock),
		.rise     (down_rise)
	);

	// ==========================================================
	// Operation select
	wire clear_now;
	wire load_now;
	wire count_ok;

	assign clear_now = master_clear;
	assign load_now  = ~master_clear & ~preset_load_n;
	assign count_ok  = ~master_clear & preset_load_n;

	// ==========================================================
	// Shared up and down steering lines
	wire [WIDTH-1:0] count_q;
	wire [WIDTH-1:0] count_d;
	wire [WIDTH-1:0] toggle;
	wire             up_line;
	wire             down_line;
	wire             low_bit_free;

	assign up_line   = count_ok & up_rise;
	assign down_line = count_ok & down_rise;

	// Lowest stage sees both clocks; a low clock holds it, so
	// counting with the other clock low skips by two or stalls
	assign low_bit_free = count_up_clock & count_down_clock;
	assign toggle[0]    = (up_line | down_line) & low_bit_free;

	// Upper stages toggle when all lower bits are ones (up) or
	// zeros (down); this also gives the modulo-16 wrap
	genvar gi;
	generate
		for (gi = 1; gi < WIDTH; gi = gi + 1) begin : g_steer
			assign toggle[gi] =
				(up_line & (&count_q[gi-1:0])) |
				(down_line & ~(|count_q[gi-1:0]));
		end
	endgenerate

	// ==========================================================
	// Count stages, all clocked together from the same lines
	generate
		for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
			count_bit_cell u_cell (
				.mclk     (mclk),
				.nrst     (nrst),
				.clk_en   (clk_en),
				.clear    (clear_now),
				.load     (load_now),
				.load_bit (preset_data[gi]),
				.toggle   (toggle[gi]),
				.bit_d    (count_d[gi]),
				.bit_q    (count_q[gi])
			);
		end
	endgenerate

	assign count_value = count_q;

	// ==========================================================
	// Terminal counts
	// Registered from the next count and present clock level, so
	// they follow the count clock one mclk late; a cascaded stage
	// counts on the rising return of these outputs
	wire carry_d;
	wire borrow_d;

	assign carry_d  = ~((&count_d) & ~count_up_clock);
	assign borrow_d = ~(~(|count_d) & ~count_down_clock);

	always @(posedge mclk) begin
		if (!nrst) begin
			carry_out_n  <= `TC_IDLE_LEVEL;
			borrow_out_n <= `TC_IDLE_LEVEL;
		end else if (clk_en) begin
			carry_out_n  <= carry_d;
			borrow_out_n <= borrow_d;
		end
	end

endmodule // updown_binary_counter

// >>> tb/updown_monitor.sv
// Purpose: Port checks for the up/down counter
// Assumes: Count clocks held steady while clk_en is low
// Notes:   Flags trail the clocks by one mclk edge
`timescale 1ns/10ps
module updown_monitor (
	input logic       mclk, nrst, clk_en, count_up_clock, count_down_clock,
	input logic       master_clear, preset_load_n, carry_out_n, borrow_out_n,
	input logic [3:0] preset_data, count_value
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst || !clk_en);
	wire       up = count_up_clock;
	wire       dn = count_down_clock;
	wire [3:0] q  = count_value;
	wire       go = !master_clear && preset_load_n;
	clr_zero_a: assert property (master_clear |=> q == 4'h0)
		else $error("clear");
	load_copy_a: assert property (!master_clear && !preset_load_n |=>
		q == $past(preset_data)) else $error("load");
	up_step_a: assert property (go && $rose(up) && $past(nrst && dn) && dn
		|=> q == $past(q) + 4'h1) else $error("up");
	dn_step_a: assert property (go && $rose(dn) && $past(nrst && up) && up
		|=> q == $past(q) - 4'h1) else $error("down");
	carry_flag_a: assert property ($past(nrst) |->
		carry_out_n == !(q == 4'hF && !$past(up))) else $error("carry");
	borrow_flag_a: assert property ($past(nrst) |->
		borrow_out_n == !(q == 4'h0 && !$past(dn))) else $error("borrow");
	lsb_hold_a: assert property (go && !(up && dn) |=> $stable(q[0]))
		else $error("lsb");
	count_still_a: assert property (go && !$rose(up) && !$rose(dn)
		|=> $stable(q)) else $error("drift");
endmodule // updown_monitor

bind updown_binary_counter updown_monitor u_mon (.*);

// >>> tb/next_stage_model.sv
// Purpose: Next higher counter stage
// Assumes: Flags sampled on mclk
// Notes:   Counts each rising return of a flag
`timescale 1ns/10ps
module next_stage_model (
	input  logic       mclk, nrst, carry_in_n, borrow_in_n,
	output logic [3:0] hi_count
);
	logic c_q, b_q;
	always @(posedge mclk) begin
		c_q <= carry_in_n;
		b_q <= borrow_in_n;
		hi_count <= !nrst ? 4'h0 : hi_count + 4'(carry_in_n & ~c_q)
			- 4'(borrow_in_n & ~b_q);
	end
endmodule // next_stage_model

// >>> tb/tb_top.sv
// Purpose: Directed counter checks
// Assumes: Inputs change on falling mclk
// Notes:   Flags lag the clocks by one edge
`timescale 1ns/10ps
module tb_top;
	logic       mclk = 1'b0, nrst, en, up, dn, clr, ld_n, cy_n, bw_n;
	logic [3:0] pd, q, hi;
	int         err_count, checks;
	updown_binary_counter u_dut (.mclk, .nrst, .clk_en(en),
		.count_up_clock(up), .count_down_clock(dn), .master_clear(clr),
		.preset_load_n(ld_n), .preset_data(pd), .count_value(q),
		.carry_out_n(cy_n), .borrow_out_n(bw_n));
	next_stage_model u_nxt (.mclk, .nrst, .carry_in_n(cy_n),
		.borrow_in_n(bw_n), .hi_count(hi));
	initial forever #25 mclk = ~mclk;
	task cyc(input logic u, d, c, l, input logic [3:0] p);
		@(negedge mclk);
		{up, dn, clr, ld_n, pd} = {u, d, c, l, p};
		@(posedge mclk) #1;
	endtask
	task chk(input logic [3:0] g, e);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %0t %h/%h", $time, g, e);
		end
	endtask
	task wrap_up;
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task t_load;
		cyc(1, 1, 0, 0, 4'hE);
		chk(q, 4'hE);
		cyc(0, 1, 1, 0, 4'h9);
		cyc(1, 1, 0, 1, 4'h9);
		chk(q, 4'h1);
		cyc(1, 0, 0, 0, 4'h5);
		cyc(0, 0, 0, 1, 4'h5);
		cyc(1, 0, 0, 1, 4'h5);
		chk(q, 4'h7);
	endtask
	task t_wrap;
		cyc(0, 1, 0, 0, 4'hF);
		chk({3'h0, cy_n}, 4'h0);
		cyc(1, 1, 0, 1, 4'hF);
		chk(q, 4'h0);
		cyc(1, 0, 0, 1, 4'hF);
		chk(hi, 4'h1);
		chk({3'h0, bw_n}, 4'h0);
		cyc(1, 1, 0, 1, 4'hF);
		chk(q, 4'hF);
	endtask
	// Enable low must freeze; then a mid-run reset
	task t_freeze;
		@(negedge mclk);
		en = 1'b0;
		cyc(1, 1, 0, 0, 4'h3);
		chk(q, 4'hF);
		cyc(1, 1, 1, 1, 4'h3);
		chk(q, 4'hF);
		cyc(1, 1, 0, 1, 4'h3);
		@(negedge mclk);
		en = 1'b1;
		@(posedge mclk) #1;
		chk(q, 4'hF);
		@(negedge mclk);
		nrst = 1'b0;
		@(posedge mclk) #1;
		chk(q, 4'h0);
		chk({3'h0, bw_n}, 4'h1);
		@(negedge mclk);
		nrst = 1'b1;
		cyc(1, 1, 0, 1, 4'h3);
		chk(q, 4'h0);
	endtask
	initial begin
		{nrst, up, dn, clr, ld_n, pd} = 9'h0D0;
		en = 1'b1;
		repeat (6) @(negedge mclk);
		nrst = 1'b1;
		t_load;
		t_wrap;
		t_freeze;
		wrap_up;
	end
	initial begin
		#20000 err_count++;
		wrap_up;
	end
endmodule // tb_top
